// ---- rtl/wdt_pkg.sv ----
// watchdog package: register offsets, control field layout, fuse bundle, timing counts
// assumes a single 200 MHz ref_clk domain and an 8-bit special-function register port
package wdt_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'hE1; // control register offset
  localparam logic [7:0] ADDR_RESET_CAUSE_FLAGS = 8'h97; // reset cause flags offset

  // control field positions
  localparam int BIT_RESET_EN = 7;
  localparam int BIT_NONSTOP = 6;
  localparam int BIT_RUN = 5;
  localparam int BIT_CLEAR = 4;
  localparam int BIT_IDLE = 3;
  localparam int BIT_FLAG = 0; // overflow flag in reset cause flags

  // reset values
  localparam logic [7:0] CTRL_POR_VALUE = 8'h07; // power-on value when not fused
  localparam logic [7:0] FLAGS_POR_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // counter geometry and timing
  // ----------------------------------------------------------------
  localparam int COUNT_W = 9;
  localparam int PRESC_W = 7;
  localparam int CLK_HZ = 200_000_000;
  localparam int RC_HZ = 32_000; // low-power rc oscillator rate
  localparam int RC_TICK_CYCLES = CLK_HZ / RC_HZ; // ref_clk cycles per rc tick, rounded down

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic reset_enable_fuse;
    logic nonstop_fuse;
    logic auto_enable_fuse;
    logic idle_count_fuse;
    logic [2:0] period_select_fuse;
    logic write_protect_fuse;
  } fuse_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic privileged;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic overflow_reset_enable;
    logic nonstop_in_powerdown;
    logic run_enable;
    logic count_in_idle;
    logic [2:0] period_select;
  } ctrl_t;

endpackage : wdt_pkg

// ---- rtl/rc_tick_gen.sv ----
// rc_tick_gen: one-cycle enable pulses at the low-power rc oscillator rate
// assumes ref_clk; the oscillator is modelled as a divider that runs only when asked
`timescale 1ns/10ps
module rc_tick_gen #(
  parameter int DIV = wdt_pkg::RC_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic run,
  output logic tick
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cnt; // divider count
    logic tick;       // registered pulse
  } tick_state_t;

  tick_state_t st_reg;
  tick_state_t st_next;

  // divider: pulse on wrap, held at zero while stopped
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.cnt = 16'h0000;
    end else if (st_reg.cnt == 16'(DIV - 1)) begin
      st_next.cnt = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

  a_tick_single: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.tick |=> !st_reg.tick)
    else $error("rc tick lasted more than one cycle");

endmodule : rc_tick_gen

// ---- rtl/wdt_prescaler.sv ----
// wdt_prescaler: 7-bit prescaler picking a divide of 1..128 by period select
// assumes tick_in is a one-cycle enable on ref_clk
`timescale 1ns/10ps
module wdt_prescaler (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic tick_in,
  input wire logic clear,
  input wire logic [2:0] period_select,
  output logic tick_out
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PRESC_W-1:0] cnt; // prescaler count
  } presc_state_t;

  presc_state_t st_reg;
  presc_state_t st_next;
  logic [PRESC_W-1:0] mask; // low bits that must all be one

  // divide by 2^period_select
  always_comb begin
    mask = PRESC_W'((8'h01 << period_select) - 8'h01);
    st_next = st_reg;
    tick_out = tick_in && ((st_reg.cnt & mask) == mask);
    if (clear) begin
      st_next.cnt = '0;
    end else if (tick_in) begin
      st_next.cnt = st_reg.cnt + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_presc_div1: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (period_select == 3'h0 && tick_in) |-> tick_out)
    else $error("divide by one missed a tick");

endmodule : wdt_prescaler

// ---- rtl/watchdog_timer.sv ----
// watchdog_timer: 9-bit watchdog with prescaler, control register and overflow flag
// assumes a cpu special-function register port on ref_clk, fuse straps stable after
// power-on, power-on reset on arst_n and warm resets that must not touch this block
`timescale 1ns/10ps

// Function
// - 9-bit counter, 7-bit prescaler, one control register
// - prescaler clocked from the 32 kHz oscillator
// - overflow sets flag; interrupt needs both enables
// - reset enable makes overflow reset the system
// - writing one to clear zeroes the counter
// - run enable sticks until power-on or privileged write
// - control survives warm resets; only power-on alters
// - top bits set-only outside privileged page
// - idle counting follows idle bit or nonstop fuse
// - nonstop bit keeps counting and wakes power-down
// - period select divides by one to 128
// - flag set by hardware, cleared writing one
// - auto-enable fuse loads control at power-up
// - without auto-enable fuse watchdog starts disabled
// - both fuses block all control writes except clear
// - write-protect fuse locks mode and period fields
// - reset-enable and nonstop power-up follow fuses
module watchdog_timer #(
  // rc oscillator divide from ref_clk
  parameter int RC_DIV = wdt_pkg::RC_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire wdt_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire wdt_pkg::fuse_t fuses,
  input wire logic cpu_idle,
  input wire logic cpu_powerdown,
  input wire logic overflow_irq_enable,
  input wire logic system_flag_irq_enable,
  output logic irq,
  output logic system_reset,
  output logic wakeup
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ctrl_t ctrl;                 // control register bits
    logic loaded;                // fuse load done after power-on
    logic [COUNT_W-1:0] count;   // watchdog counter
    logic overflow_flag;         // sticky overflow flag
    logic sys_rst;               // registered reset request
    logic wake;                  // registered wake pulse
    logic [7:0] rdata;           // read data
  } wdt_state_t;

  wdt_state_t st_reg;
  wdt_state_t st_next;

  logic rc_tick;      // 32 kHz enable
  logic count_tick;   // prescaled enable
  logic counting;     // counter allowed to advance
  logic clear_hit;    // counter clear write
  logic overflow;     // counter wraps this cycle
  logic wr_ctrl;      // write to control address
  logic wr_flags;     // write to flags address
  logic locked_all;   // both fuses programmed
  fuse_t fuse_q;      // fuses, stable after power-on

  assign fuse_q = fuses;

  // pack control bits for read-back; the one-shot clear bit always reads as zero
  function automatic logic [7:0] ctrl_byte(input ctrl_t c);
    ctrl_byte = {c.overflow_reset_enable, c.nonstop_in_powerdown, c.run_enable, 1'b0,
                 c.count_in_idle, c.period_select};
  endfunction : ctrl_byte

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  // oscillator runs while enabled; in power-down only with nonstop set, in idle only with idle bit or nonstop fuse
  assign counting = st_reg.ctrl.run_enable && st_reg.loaded
    && !(cpu_powerdown && !st_reg.ctrl.nonstop_in_powerdown)
    && !(cpu_idle && !cpu_powerdown && !st_reg.ctrl.count_in_idle
         && !fuse_q.nonstop_fuse);

  rc_tick_gen #(
    .DIV(RC_DIV)
  ) u_rc (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .run(counting),
    .tick(rc_tick)
  );

  wdt_prescaler u_presc (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick_in(rc_tick),
    .clear(clear_hit),
    .period_select(st_reg.ctrl.period_select),
    .tick_out(count_tick)
  );

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign wr_ctrl = sfr_req.wr && (sfr_req.addr == ADDR_WATCHDOG_CONTROL);
  assign wr_flags = sfr_req.wr && (sfr_req.addr == ADDR_RESET_CAUSE_FLAGS);
  assign locked_all = fuse_q.auto_enable_fuse && fuse_q.write_protect_fuse;
  assign clear_hit = wr_ctrl && sfr_req.wdata[BIT_CLEAR];
  assign overflow = count_tick && (st_reg.count == '1) && !clear_hit;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.sys_rst = 1'b0;
    st_next.wake = 1'b0;

    // power-up load from fuses, once after power-on release
    if (!st_reg.loaded) begin
      st_next.loaded = 1'b1;
      if (fuse_q.auto_enable_fuse) begin
        st_next.ctrl.run_enable = 1'b1;
        st_next.ctrl.count_in_idle = fuse_q.idle_count_fuse;
        st_next.ctrl.period_select = fuse_q.period_select_fuse;
      end
      // reset-enable and nonstop follow their fuses at power-up
      st_next.ctrl.overflow_reset_enable = fuse_q.reset_enable_fuse;
      st_next.ctrl.nonstop_in_powerdown = fuse_q.nonstop_fuse;
    end else if (wr_ctrl && !locked_all) begin
      // set-only top bits on normal pages; privileged page writes freely
      if (sfr_req.privileged) begin
        st_next.ctrl.run_enable = sfr_req.wdata[BIT_RUN];
      end else begin
        st_next.ctrl.run_enable = st_reg.ctrl.run_enable | sfr_req.wdata[BIT_RUN];
      end
      if (!fuse_q.write_protect_fuse) begin
        if (sfr_req.privileged) begin
          st_next.ctrl.overflow_reset_enable = sfr_req.wdata[BIT_RESET_EN];
          st_next.ctrl.nonstop_in_powerdown = sfr_req.wdata[BIT_NONSTOP];
        end else begin
          st_next.ctrl.overflow_reset_enable = st_reg.ctrl.overflow_reset_enable
            | sfr_req.wdata[BIT_RESET_EN];
          st_next.ctrl.nonstop_in_powerdown = st_reg.ctrl.nonstop_in_powerdown
            | sfr_req.wdata[BIT_NONSTOP];
        end
        st_next.ctrl.count_in_idle = sfr_req.wdata[BIT_IDLE];
        st_next.ctrl.period_select = sfr_req.wdata[2:0];
      end
    end

    // counter: clear write, else advance on prescaled tick
    if (clear_hit) begin
      st_next.count = '0;
    end else if (count_tick) begin
      st_next.count = st_reg.count + 9'h001; // wraps to zero on overflow
    end

    // flag: software writes one to clear, set wins
    if (wr_flags && sfr_req.wdata[BIT_FLAG]) begin
      st_next.overflow_flag = 1'b0;
    end
    if (overflow) begin
      st_next.overflow_flag = 1'b1;
      st_next.sys_rst = st_reg.ctrl.overflow_reset_enable;
      st_next.wake = cpu_powerdown;
    end

    // read mux, registered
    if (sfr_req.rd && sfr_req.addr == ADDR_WATCHDOG_CONTROL) begin
      st_next.rdata = ctrl_byte(st_reg.ctrl);
    end else if (sfr_req.rd && sfr_req.addr == ADDR_RESET_CAUSE_FLAGS) begin
      st_next.rdata = {7'h00, st_reg.overflow_flag};
    end else begin
      st_next.rdata = 8'h00;
    end
  end

  // power-on reset only; warm resets never reach this block
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg.ctrl <= ctrl_t'(CTRL_POR_VALUE[7:5] == 3'h0 ? {4'h0, CTRL_POR_VALUE[2:0]}
                                                        : 7'h00);
      st_reg.loaded <= 1'b0;
      st_reg.count <= '0;
      st_reg.overflow_flag <= FLAGS_POR_VALUE[BIT_FLAG];
      st_reg.sys_rst <= 1'b0;
      st_reg.wake <= 1'b0;
      st_reg.rdata <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sfr_rdata = st_reg.rdata;
  assign irq = st_reg.overflow_flag && overflow_irq_enable && system_flag_irq_enable;
  assign system_reset = st_reg.sys_rst;
  assign wakeup = st_reg.wake || (cpu_powerdown && irq);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_flag_on_ovf: assert property (@(posedge ref_clk) disable iff (!arst_n)
    overflow |=> st_reg.overflow_flag)
    else $error("overflow did not set flag");

  a_rst_on_ovf: assert property (@(posedge ref_clk) disable iff (!arst_n)
    overflow |=> (system_reset == $past(st_reg.ctrl.overflow_reset_enable)))
    else $error("reset request mismatch on overflow");

  a_clear_count: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clear_hit |=> (st_reg.count == 9'h000))
    else $error("clear write did not zero counter");

  a_run_sticky: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_reg.loaded && st_reg.ctrl.run_enable && !(wr_ctrl && sfr_req.privileged))
      |=> st_reg.ctrl.run_enable)
    else $error("run enable dropped without privileged write");

  a_topbit_setonly: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_reg.loaded && wr_ctrl && !sfr_req.privileged && st_reg.ctrl.overflow_reset_enable)
      |=> st_reg.ctrl.overflow_reset_enable)
    else $error("reset enable cleared from normal page");

  a_lock_all: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_reg.loaded && locked_all) |=> $stable(st_reg.ctrl))
    else $error("control changed while fully locked");

  a_wp_fields: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_reg.loaded && fuse_q.write_protect_fuse)
      |=> $stable(st_reg.ctrl.period_select) && $stable(st_reg.ctrl.count_in_idle))
    else $error("protected fields changed");

  a_idle_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cpu_idle && !cpu_powerdown && !st_reg.ctrl.count_in_idle && !fuse_q.nonstop_fuse)
      |-> !counting)
    else $error("counting in idle while stopped");

  a_pd_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cpu_powerdown && !st_reg.ctrl.nonstop_in_powerdown) |-> !counting)
    else $error("counting in power-down without nonstop");

  a_fuse_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!st_reg.loaded && fuse_q.auto_enable_fuse) |=> st_reg.ctrl.run_enable)
    else $error("auto-enable fuse did not start watchdog");

  a_no_auto: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!st_reg.loaded && !fuse_q.auto_enable_fuse) |=> !st_reg.ctrl.run_enable)
    else $error("watchdog running without enable");

  // only hardware sets the flag, and only on an overflow
  a_flag_no_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!overflow && !st_reg.overflow_flag) |=> !st_reg.overflow_flag)
    else $error("flag set without overflow");

  // write of one clears the flag unless an overflow lands in the same cycle
  a_flag_wr_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (wr_flags && sfr_req.wdata[BIT_FLAG] && !overflow) |=> !st_reg.overflow_flag)
    else $error("flag not cleared by write of one");

  // a set flag survives anything but a clearing write
  a_flag_wr_keep: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_reg.overflow_flag && !(wr_flags && sfr_req.wdata[BIT_FLAG]))
      |=> st_reg.overflow_flag)
    else $error("flag lost without a clearing write");

  // interrupt only with flag and both enables
  a_irq_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
    irq |-> (st_reg.overflow_flag && overflow_irq_enable && system_flag_irq_enable))
    else $error("interrupt without flag and both enables");

  // counter advances by one per prescaled tick, wrapping at its width
  a_count_step: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (count_tick && !clear_hit)
      |=> (st_reg.count == COUNT_W'($past(st_reg.count) + 9'h001)))
    else $error("counter did not step on tick");

  // counter holds between prescaled ticks
  a_count_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!count_tick && !clear_hit) |=> $stable(st_reg.count))
    else $error("counter moved without a tick");

  // a stopped oscillator gives no time base ticks
  a_rc_stopped: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !counting |=> !rc_tick)
    else $error("oscillator tick while stopped");

  // no reset request while reset enable is clear
  a_no_rst_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !st_reg.ctrl.overflow_reset_enable |=> !system_reset)
    else $error("reset request with reset enable clear");

  // nonstop bit is set-only outside the privileged page
  a_nonstop_setonly: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_reg.loaded && wr_ctrl && !sfr_req.privileged && st_reg.ctrl.nonstop_in_powerdown)
      |=> st_reg.ctrl.nonstop_in_powerdown)
    else $error("nonstop cleared from normal page");

  // once loaded, only a register write moves the control bits
  a_ctrl_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_reg.loaded && !wr_ctrl) |=> $stable(st_reg.ctrl))
    else $error("control changed without a write");

  // overflow in power-down raises a wake request
  a_wake_pd: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (overflow && cpu_powerdown) |=> wakeup)
    else $error("overflow in power-down did not wake");

endmodule : watchdog_timer

// ---- sim/test_watchdog_timer.sv ----
// test_watchdog_timer: self-checking bench for the watchdog, register access through the
// special-function register port, fuse straps applied across power-on resets
// assumes wdt_pkg and the design files are compiled first; RC_DIV shortened to 2
`timescale 1ns/10ps
module test_watchdog_timer;
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  localparam int D = 2; // shortened rc tick divide
  localparam int LIMIT = 40000; // cycle ceiling for the whole run
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  sfr_req_t sfr_req = '0;
  fuse_t fuses = '0;
  logic cpu_idle = 1'b0;
  logic cpu_powerdown = 1'b0;
  logic overflow_irq_enable = 1'b1;
  logic system_flag_irq_enable = 1'b1;
  logic [7:0] sfr_rdata;
  logic irq;
  logic system_reset;
  logic wakeup;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int rst_hi = 0; // cycles with system_reset high
  int wake_hi = 0; // cycles with wakeup high
  integer seed = 32'h6ff90910;
  logic [7:0] exp_q[$]; // expected read data, oldest first
  string name_q[$]; // what each expected read is
  logic rd_seen = 1'b0; // read taken at the last edge

  // free-running clock, 5 ns period
  always #2.5 ref_clk = ~ref_clk;

  watchdog_timer #(.RC_DIV(D)) dut (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata),
    .fuses(fuses),
    .cpu_idle(cpu_idle),
    .cpu_powerdown(cpu_powerdown),
    .overflow_irq_enable(overflow_irq_enable),
    .system_flag_irq_enable(system_flag_irq_enable),
    .irq(irq),
    .system_reset(system_reset),
    .wakeup(wakeup)
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // remember which edge took a read
  always @(posedge ref_clk) begin
    rd_seen <= sfr_req.rd;
  end

  // read data stands one cycle after the read: compare against the oldest note
  always @(negedge ref_clk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      chk(name_q.pop_front(), sfr_rdata, exp_q.pop_front());
    end
  end

  // pulse counters and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (system_reset === 1'b1) rst_hi++;
    if (wakeup === 1'b1) wake_hi++;
    if (cyc > LIMIT) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask : step

  // one write, taken at the edge after it is set up
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic p);
    step();
    sfr_req.wr = 1'b1;
    sfr_req.privileged = p;
    sfr_req.addr = a;
    sfr_req.wdata = d;
    step();
    sfr_req = '0;
  endtask : wr

  // one read; the expectation goes on the queue first
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    exp_q.push_back(exp);
    name_q.push_back(what);
    step();
    sfr_req.rd = 1'b1;
    sfr_req.addr = a;
    step();
    sfr_req = '0;
    step();
  endtask : rd

  // power-on reset with new fuse straps
  task automatic por(input fuse_t f);
    arst_n = 1'b0;
    fuses = f;
    cpu_idle = 1'b0;
    cpu_powerdown = 1'b0;
    repeat (20) step();
    arst_n = 1'b1;
    step();
    step();
    rst_hi = 0;
    wake_hi = 0;
  endtask : por

  // wait for the flag through irq and check the overflow time window
  task automatic wait_ovf(input int p, input string what);
    int lo;
    int hi;
    int n;
    lo = ((511 * D) << p) - 4;
    hi = ((512 * D) << p) + 4;
    n = 0;
    while (irq !== 1'b1 && n < hi + 10) begin
      step();
      n++;
    end
    chk(what, 8'(n >= lo && n <= hi), 8'h01);
  endtask : wait_ovf

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    fuse_t f;
    f = '0;
    por(f);
    // register map after a plain power-on
    rd(ADDR_WATCHDOG_CONTROL, 8'h07, "ctrl_por");
    rd(ADDR_RESET_CAUSE_FLAGS, 8'h00, "flag_por");
    wr(8'h55, 8'($random(seed)), 1'b0);
    rd(8'h55, 8'h00, "unmapped");
    rd(ADDR_WATCHDOG_CONTROL, 8'h07, "ctrl_untouched");
    // set-only top bits and privileged undo
    wr(ADDR_WATCHDOG_CONTROL, 8'h34, 1'b0);
    rd(ADDR_WATCHDOG_CONTROL, 8'h24, "ctrl_run");
    wr(ADDR_WATCHDOG_CONTROL, 8'h00, 1'b0);
    rd(ADDR_WATCHDOG_CONTROL, 8'h20, "run_sticks");
    wr(ADDR_WATCHDOG_CONTROL, 8'hC8, 1'b0);
    rd(ADDR_WATCHDOG_CONTROL, 8'hE8, "set_only");
    wr(ADDR_WATCHDOG_CONTROL, 8'h00, 1'b0);
    rd(ADDR_WATCHDOG_CONTROL, 8'hE0, "no_clear");
    wr(ADDR_WATCHDOG_CONTROL, 8'h00, 1'b1);
    rd(ADDR_WATCHDOG_CONTROL, 8'h00, "priv_clear");
    // overflow time doubles per period code, no reset without enable
    for (int p = 0; p < 4; p++) begin
      por(f);
      wr(ADDR_WATCHDOG_CONTROL, {5'b00110, 3'(p)}, 1'b0);
      wait_ovf(p, "period");
      step();
      chk("rst_none", 8'(rst_hi), 8'h00);
    end
    // interrupt needs both enables, flag write-one-to-clear
    overflow_irq_enable = 1'b0;
    step();
    chk("irq_mask_a", irq, 1'b0);
    overflow_irq_enable = 1'b1;
    system_flag_irq_enable = 1'b0;
    step();
    chk("irq_mask_b", irq, 1'b0);
    system_flag_irq_enable = 1'b1;
    rd(ADDR_RESET_CAUSE_FLAGS, 8'h01, "flag_set");
    wr(ADDR_RESET_CAUSE_FLAGS, 8'($random(seed)) & 8'hFE, 1'b0);
    rd(ADDR_RESET_CAUSE_FLAGS, 8'h01, "flag_keep");
    wr(ADDR_RESET_CAUSE_FLAGS, 8'h01, 1'b0);
    rd(ADDR_RESET_CAUSE_FLAGS, 8'h00, "flag_cleared");
    // a clear in mid-count restarts the full period
    por(f);
    wr(ADDR_WATCHDOG_CONTROL, 8'h30, 1'b0);
    repeat (700 + ($unsigned($random(seed)) % 200)) step();
    wr(ADDR_WATCHDOG_CONTROL, 8'h10, 1'b0);
    wait_ovf(0, "clear_restart");
    // reset enable gives one reset pulse, control survives it
    por(f);
    wr(ADDR_WATCHDOG_CONTROL, 8'hB0, 1'b0);
    wait_ovf(0, "reset_ovf");
    step();
    chk("rst_pulse", 8'(rst_hi), 8'h01);
    rd(ADDR_WATCHDOG_CONTROL, 8'hA0, "ctrl_kept");
    // idle stops the count unless the idle bit is set
    por(f);
    cpu_idle = 1'b1;
    wr(ADDR_WATCHDOG_CONTROL, 8'h30, 1'b0);
    repeat (1200) step();
    chk("idle_stop", irq, 1'b0);
    wr(ADDR_WATCHDOG_CONTROL, 8'h38, 1'b0);
    wait_ovf(0, "idle_count");
    // power-down counts only with the nonstop bit, then wakes
    por(f);
    cpu_powerdown = 1'b1;
    wr(ADDR_WATCHDOG_CONTROL, 8'h30, 1'b0);
    repeat (1200) step();
    chk("pd_stop", irq, 1'b0);
    chk("pd_nowake", 8'(wake_hi), 8'h00);
    wr(ADDR_WATCHDOG_CONTROL, 8'h70, 1'b0);
    wait_ovf(0, "pd_count");
    step();
    chk("pd_wake", 8'(wake_hi != 0), 8'h01);
    // fuse load at power-up
    f = '{1'b1, 1'b1, 1'b1, 1'b1, 3'b101, 1'b0};
    por(f);
    rd(ADDR_WATCHDOG_CONTROL, 8'hED, "fuse_load");
    // write-protect alone locks the mode and period fields
    f = '0;
    f.write_protect_fuse = 1'b1;
    por(f);
    wr(ADDR_WATCHDOG_CONTROL, 8'hFF, 1'b0);
    rd(ADDR_WATCHDOG_CONTROL, 8'h27, "wp_fields");
    // both fuses: everything locked except the clear
    f.auto_enable_fuse = 1'b1;
    f.nonstop_fuse = 1'b1;
    por(f);
    rd(ADDR_WATCHDOG_CONTROL, 8'h60, "lock_load");
    wr(ADDR_WATCHDOG_CONTROL, 8'h00, 1'b1);
    rd(ADDR_WATCHDOG_CONTROL, 8'h60, "lock_priv");
    cpu_idle = 1'b1;
    wr(ADDR_WATCHDOG_CONTROL, 8'h10, 1'b0);
    wait_ovf(0, "lock_clear");
    tally_and_finish();
  end

endmodule : test_watchdog_timer
